// File: dcts_pkg.sv
package dcts_pkg;

  // Datapath widths
  localparam int ACC_W  = 32;
  localparam int WORD_W = 16;
  localparam int LEN_W  = 8;

  // Operation codes presented on op_sel
  typedef enum logic [2:0] {
    hex_to_ascii_op       = 3'h0,
    seven_segment_op      = 3'h1,
    gray_to_bcd_op        = 3'h2,
    digit_shuffle_op      = 3'h3,
    table_fill_op         = 3'h4,
    table_find_equal_op   = 3'h5,
    table_find_greater_op = 3'h6
  } dcts_op_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_read  = 4'h2,
    st_check = 4'h4,
    st_write = 4'h8
  } dcts_state_t;

  // Character and digit constants
  localparam logic [7:0] ASC_DIGIT_BASE = 8'h30;
  localparam logic [7:0] ASC_ALPHA_BASE = 8'h41;
  localparam logic [7:0] ASC_ALPHA_LAST = 8'h46;
  localparam logic [7:0] ASC_DIGIT_LAST = 8'h39;
  localparam logic [3:0] HEX_TEN        = 4'ha;
  localparam logic [3:0] ORDER_FIRST    = 4'h1;
  localparam logic [3:0] ORDER_LAST     = 4'h8;
  localparam logic [3:0] BCD_ADJ_LIMIT  = 4'h5;
  localparam logic [3:0] BCD_ADJ        = 4'h3;
  localparam int         SHUF_DIGITS    = 8;
  localparam int         SEG_DIGITS     = 4;
  localparam int         GRAY_W         = 16;
  localparam int         GRAY_BIN_W     = 10;
  localparam int         BCD_FULL_W     = 16;
  localparam int         GRAY_RES_W     = 10;

  // Seven-segment patterns, bit 0 = segment a .. bit 6 = segment g
  localparam logic [6:0] SEG_TABLE [16] = '{
    7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71
  };

  // Whole state of the unit
  typedef struct packed {
    dcts_state_t        st;
    dcts_op_t           op;
    logic [ACC_W-1:0]   acc;
    logic               not_found;
    logic               done;
    logic               busy;
    logic [WORD_W-1:0]  mem_addr;
    logic [WORD_W-1:0]  mem_wdata;
    logic               mem_we;
    logic               mem_re;
    logic [LEN_W-1:0]   idx;
    logic [LEN_W-1:0]   len;
    logic [WORD_W-1:0]  src;
    logic [WORD_W-1:0]  key;
    logic [WORD_W-1:0]  hold;
    logic               phase;
  } dcts_regs_t;

endpackage

// File: dcts_unit.sv
`timescale 1ns/100ps
// Function
// RULE1 - Hex nibbles 0-9 become codes 30-39, A-F become 41-46.
// RULE2 - Each hex word expands to two ASCII words, doubling table size.
// RULE3 - Segment op turns accumulator binary into seven-segment pattern in accumulator.
// RULE4 - Gray op converts 16-bit Gray to BCD in low 10 bits, upper 22 cleared.
// RULE5 - Program subtracts BCD 76 (360 counts) or 152 (720 counts) afterwards.
// RULE6 - Shuffle moves up to 8 stack digits to accumulator-given positions 1..8.
// RULE7 - Order digit 0 or 9-F yields zero in that result position.
// RULE8 - Duplicate destinations: most significant duplicate order digit wins.
// RULE9 - Fill writes one value into up to 255 words from accumulator start.
// RULE10 - Program loads length, start and offset into stack and accumulator before find.
// RULE11 - Successful find returns offset of first equal word in accumulator.
// RULE12 - Offset outside table or no match sets not-found; no match returns 0.
// RULE13 - Find pointer counts from 0 and is held in accumulator.
// RULE14 - Not-found flag holds until the next operation using it.
// RULE15 - Find-greater locates first word above search value; length stack, start accumulator.
// RULE16 - Searches scan ascending from the offset and stop at first hit.
// RULE17 - Program gives lengths, addresses and offsets in hexadecimal.
module dcts_unit
  import dcts_pkg::*;
(
  input  wire logic              sys_clk,        // System clock, 100 MHz
  input  wire logic              sys_rst,        // Synchronous reset, active high
  input  wire logic              clk_en,         // Freezes all state while low
  input  wire logic              op_start,       // Start an operation (taken when idle)
  input  wire logic [2:0]        op_sel,         // Operation code
  input  wire logic [ACC_W-1:0]  acc_in,         // Accumulator value
  input  wire logic [ACC_W-1:0]  stack1_in,      // First stack level
  input  wire logic [ACC_W-1:0]  stack2_in,      // Second stack level
  input  wire logic [WORD_W-1:0] operand_in,     // Instruction operand value
  input  wire logic [WORD_W-1:0] mem_rdata,      // Word memory read data
  output logic      [ACC_W-1:0]  acc_out,        // Resulting accumulator
  output logic                   done,           // Operation finished
  output logic                   busy,           // Table operation in progress
  output logic                   not_found_flag, // Search failed
  output logic      [WORD_W-1:0] mem_addr,       // Word memory address
  output logic      [WORD_W-1:0] mem_wdata,      // Word memory write data
  output logic                   mem_we,         // Word memory write strobe
  output logic                   mem_re          // Word memory read strobe
);

  dcts_regs_t r;
  dcts_regs_t next_r;
  logic [LEN_W:0] idx_inc;
  logic           last_word;
  logic           hit;

  // One nibble to its ASCII code
  function automatic logic [7:0] hex_ascii(input logic [3:0] n);
    if (n < HEX_TEN) begin
      hex_ascii = ASC_DIGIT_BASE + {4'h0, n};  // RULE1
    end else begin
      hex_ascii = ASC_ALPHA_BASE + {4'h0, n - HEX_TEN};  // RULE1
    end
  endfunction

  // One byte to two ASCII characters packed in a word
  function automatic logic [WORD_W-1:0] ascii_pair(input logic [7:0] b);
    ascii_pair = {hex_ascii(b[7:4]), hex_ascii(b[3:0])};
  endfunction

  // Legal ASCII hex character check
  function automatic logic ascii_ok(input logic [7:0] c);
    ascii_ok = (c >= ASC_DIGIT_BASE && c <= ASC_DIGIT_LAST) || (c >= ASC_ALPHA_BASE && c <= ASC_ALPHA_LAST);
  endfunction

  // Four binary digits to four segment bytes
  function automatic logic [ACC_W-1:0] seg_encode(input logic [WORD_W-1:0] v);
    seg_encode = '0;
    for (int i = 0; i < SEG_DIGITS; i++) begin
      seg_encode[i*8 +: 8] = {1'b0, SEG_TABLE[v[i*4 +: 4]]};  // RULE3
    end
  endfunction

  // Gray to binary, then binary to BCD by shift-and-add
  function automatic logic [ACC_W-1:0] gray_bcd(input logic [GRAY_W-1:0] g);
    logic [GRAY_W-1:0]     bin;
    logic [BCD_FULL_W-1:0] bcd;
    bin = '0;
    bcd = '0;
    for (int i = 0; i < GRAY_W; i++) begin
      bin[i] = ^(g >> i);
    end
    for (int i = GRAY_BIN_W - 1; i >= 0; i--) begin
      for (int j = 0; j < BCD_FULL_W / 4; j++) begin
        if (bcd[j*4 +: 4] >= BCD_ADJ_LIMIT) begin
          bcd[j*4 +: 4] = bcd[j*4 +: 4] + BCD_ADJ;
        end
      end
      bcd = {bcd[BCD_FULL_W-2:0], bin[i]};
    end
    gray_bcd = {{(ACC_W-GRAY_RES_W){1'b0}}, bcd[GRAY_RES_W-1:0]};  // RULE4
  endfunction

  // Digit shuffle; later (more significant) order digits overwrite earlier ones
  function automatic logic [ACC_W-1:0] shuffle(input logic [ACC_W-1:0] digits, input logic [ACC_W-1:0] order);
    logic [3:0] d;
    shuffle = '0;  // RULE7
    for (int i = 0; i < SHUF_DIGITS; i++) begin
      d = order[i*4 +: 4];
      if (d >= ORDER_FIRST && d <= ORDER_LAST) begin
        shuffle[(int'(d) - 1)*4 +: 4] = digits[i*4 +: 4];  // RULE6 RULE8
      end
    end
  endfunction

  // Table index bookkeeping and search comparison
  assign idx_inc   = {1'b0, r.idx} + {{LEN_W{1'b0}}, 1'b1};
  assign last_word = idx_inc >= {1'b0, r.len};
  assign hit       = (r.op == table_find_equal_op) ? (mem_rdata == r.key) : (mem_rdata > r.key);  // RULE11 RULE15

  // Next-state logic of the sequencer
  always_comb begin
    next_r        = r;
    next_r.done   = 1'b0;
    next_r.mem_we = 1'b0;
    next_r.mem_re = 1'b0;
    unique case (r.st)
      st_idle: begin
        if (op_start) begin
          next_r.op  = dcts_op_t'(op_sel);
          next_r.acc = acc_in;
          next_r.key = operand_in;
          next_r.idx = '0;  // RULE13
          case (op_sel)
            seven_segment_op: begin
              next_r.acc  = seg_encode(acc_in[WORD_W-1:0]);  // RULE3
              next_r.done = 1'b1;
            end
            gray_to_bcd_op: begin
              next_r.acc  = gray_bcd(acc_in[GRAY_W-1:0]);  // RULE4
              next_r.done = 1'b1;
            end
            digit_shuffle_op: begin
              next_r.acc  = shuffle(stack1_in, acc_in);  // RULE6
              next_r.done = 1'b1;
            end
            hex_to_ascii_op, table_fill_op: begin
              next_r.len       = stack1_in[LEN_W-1:0];  // RULE9
              next_r.src       = acc_in[WORD_W-1:0];
              next_r.mem_addr  = acc_in[WORD_W-1:0];
              next_r.mem_wdata = operand_in;  // RULE9
              next_r.phase     = 1'b0;
              if (stack1_in[LEN_W-1:0] == '0) begin
                next_r.done = 1'b1;
              end else begin
                next_r.busy   = 1'b1;
                next_r.mem_re = (op_sel == hex_to_ascii_op);
                next_r.mem_we = (op_sel == table_fill_op);
                next_r.st     = (op_sel == hex_to_ascii_op) ? st_read : st_write;
              end
            end
            table_find_equal_op, table_find_greater_op: begin
              next_r.not_found = 1'b0;  // RULE14
              if (op_sel == table_find_equal_op) begin
                next_r.len      = stack2_in[LEN_W-1:0];
                next_r.idx      = acc_in[LEN_W-1:0];
                next_r.mem_addr = stack1_in[WORD_W-1:0] + acc_in[WORD_W-1:0];
              end else begin
                next_r.len      = stack1_in[LEN_W-1:0];  // RULE15
                next_r.mem_addr = acc_in[WORD_W-1:0];
              end
              if ((op_sel == table_find_equal_op && acc_in[WORD_W-1:0] >= {8'h00, stack2_in[LEN_W-1:0]})
                  || (op_sel == table_find_greater_op && stack1_in[LEN_W-1:0] == '0)) begin
                next_r.acc       = '0;
                next_r.not_found = 1'b1;  // RULE12
                next_r.done      = 1'b1;
              end else begin
                next_r.busy   = 1'b1;
                next_r.mem_re = 1'b1;
                next_r.st     = st_read;
              end
            end
            default: begin
              next_r.done = 1'b1;
            end
          endcase
        end
      end
      st_read: begin
        next_r.st = st_check;
      end
      st_check: begin
        if (r.op == hex_to_ascii_op) begin
          next_r.hold      = mem_rdata;
          next_r.mem_addr  = r.key;
          next_r.mem_wdata = ascii_pair(mem_rdata[7:0]);  // RULE1
          next_r.mem_we    = 1'b1;
          next_r.phase     = 1'b0;
          next_r.st        = st_write;
        end else if (hit) begin
          next_r.acc  = {{(ACC_W-LEN_W){1'b0}}, r.idx};  // RULE11 RULE16
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st   = st_idle;
        end else if (last_word) begin
          next_r.acc       = '0;  // RULE12
          next_r.not_found = 1'b1;
          next_r.done      = 1'b1;
          next_r.busy      = 1'b0;
          next_r.st        = st_idle;
        end else begin
          next_r.idx      = idx_inc[LEN_W-1:0];  // RULE16
          next_r.mem_addr = r.mem_addr + 16'h0001;
          next_r.mem_re   = 1'b1;
          next_r.st       = st_read;
        end
      end
      st_write: begin
        if (r.op == hex_to_ascii_op && !r.phase) begin
          next_r.mem_addr  = r.mem_addr + 16'h0001;  // RULE2
          next_r.mem_wdata = ascii_pair(r.hold[15:8]);
          next_r.mem_we    = 1'b1;
          next_r.phase     = 1'b1;
        end else if (last_word) begin
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st   = st_idle;
        end else if (r.op == hex_to_ascii_op) begin
          next_r.idx      = idx_inc[LEN_W-1:0];
          next_r.key      = r.mem_addr + 16'h0001;
          next_r.src      = r.src + 16'h0001;
          next_r.mem_addr = r.src + 16'h0001;
          next_r.mem_re   = 1'b1;
          next_r.st       = st_read;
        end else begin
          next_r.idx      = idx_inc[LEN_W-1:0];  // RULE9
          next_r.mem_addr = r.mem_addr + 16'h0001;
          next_r.mem_we   = 1'b1;
        end
      end
      default: begin
        next_r.st   = st_idle;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // State register with clock enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r    <= '0;
      r.st <= st_idle;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign acc_out        = r.acc;
  assign done           = r.done;
  assign busy           = r.busy;
  assign not_found_flag = r.not_found;
  assign mem_addr       = r.mem_addr;
  assign mem_wdata      = r.mem_wdata;
  assign mem_we         = r.mem_we;
  assign mem_re         = r.mem_re;

  // Checks on the produced results
  hta_ascii_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
    (r.mem_we && r.op == hex_to_ascii_op) |-> (ascii_ok(r.mem_wdata[7:0]) && ascii_ok(r.mem_wdata[15:8])))
    else $error("ASCII write holds a non-hex character");
  hta_second_word_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
    (r.st == st_write && r.op == hex_to_ascii_op && !r.phase && clk_en)
      |=> (r.mem_we && r.phase && r.mem_addr == $past(r.mem_addr) + 16'h0001))
    else $error("Second ASCII word not written at next address");
  seg_pattern_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    (r.done && r.op == seven_segment_op)
      |-> (!r.acc[7] && !r.acc[15] && !r.acc[23] && !r.acc[31] && r.acc[6:0] != 7'h00 && r.acc[30:24] != 7'h00))
    else $error("Segment pattern malformed");
  gray_upper_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
    (r.done && r.op == gray_to_bcd_op) |-> (r.acc[ACC_W-1:GRAY_RES_W] == '0))
    else $error("Gray result upper bits not cleared");
  shuffle_invalid_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
    (r.st == st_idle && op_start && clk_en && op_sel == digit_shuffle_op && acc_in == 32'h9abc_def0)
      |=> (r.done && r.acc == '0))
    else $error("Invalid order digits did not give zero");
  shuffle_dup_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    (r.st == st_idle && op_start && clk_en && op_sel == digit_shuffle_op && acc_in == 32'h1111_1111)
      |=> (r.acc == {28'h000_0000, $past(stack1_in[31:28])}))
    else $error("Most significant duplicate did not win");
  fill_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
    (r.mem_we && r.op == table_fill_op && clk_en) |=> (!r.mem_we || $stable(r.mem_wdata)))
    else $error("Fill value changed within the table");
  notfound_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE12
    (r.done && r.not_found && (r.op == table_find_equal_op || r.op == table_find_greater_op)) |-> (r.acc == '0))
    else $error("Not-found result is not zero");
  found_offset_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
    (r.done && !r.not_found && (r.op == table_find_equal_op || r.op == table_find_greater_op))
      |-> (r.acc[ACC_W-1:LEN_W] == '0 && r.acc[LEN_W-1:0] < r.len))
    else $error("Found offset outside the table");
  scan_ascend_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE16
    (r.st == st_read && $past(r.st) == st_check && r.op != hex_to_ascii_op)
      |-> (r.mem_addr == $past(r.mem_addr) + 16'h0001))
    else $error("Search did not step to the next address");

endmodule

// File: dcts_mem_model.sv
`timescale 1ns/100ps
module dcts_mem_model
  import dcts_pkg::*;
(
  input  wire logic              sys_clk,   // Clock
  input  wire logic [WORD_W-1:0] mem_addr,  // Word address
  input  wire logic [WORD_W-1:0] mem_wdata, // Write data
  input  wire logic              mem_we,    // Write strobe
  input  wire logic              mem_re,    // Read strobe
  output logic      [WORD_W-1:0] mem_rdata  // Read data, one cycle after strobe
);
  logic [WORD_W-1:0] mem [512];

  initial mem_rdata = '0;

  // Synchronous word memory; read data toggles when no read returns
  always @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_addr[8:0]] <= mem_wdata;
    end
    if (mem_re) begin
      mem_rdata <= mem[mem_addr[8:0]];
    end else begin
      mem_rdata <= ~mem_rdata;  // Stale data inverts every cycle, so it matches the last read again on alternate cycles
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  import dcts_pkg::*;
  logic              sys_clk;
  logic              sys_rst;
  logic              clk_en;
  logic              op_start;
  logic [2:0]        op_sel;
  logic [ACC_W-1:0]  acc_in;
  logic [ACC_W-1:0]  stack1_in;
  logic [ACC_W-1:0]  stack2_in;
  logic [ACC_W-1:0]  acc_out;
  logic [WORD_W-1:0] operand_in;
  logic [WORD_W-1:0] mem_rdata;
  logic [WORD_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata;
  logic              done;
  logic              busy;
  logic              not_found_flag;
  logic              mem_we;
  logic              mem_re;
  int                n_fail;
  int                tests_run;
  // Expected segment patterns, bit 0 = segment a
  localparam logic [6:0] SEG_EXP [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                          7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};

  dcts_unit i_dcts_unit (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .op_start(op_start),
    .op_sel(op_sel), .acc_in(acc_in), .stack1_in(stack1_in), .stack2_in(stack2_in),
    .operand_in(operand_in), .mem_rdata(mem_rdata), .acc_out(acc_out), .done(done), .busy(busy),
    .not_found_flag(not_found_flag), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re));

  dcts_mem_model i_dcts_mem_model (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for the done pulse; running out of cycles ends the run
  task automatic wait_done();
    int i;
    for (i = 0; i < 600 && done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (done !== 1'b1) begin
      n_fail++;
      $display("[FAIL] t=%0t done=%h exp=%h", $time, done, 1'b1);
      tally_and_finish();
    end
  endtask

  // One operation: start strobe for one cycle, then bounded wait for done
  task automatic run_op(input logic [2:0] op, input logic [31:0] a, s1, s2, input logic [15:0] opd);
    @(posedge sys_clk);
    op_start   <= 1'b1;
    op_sel     <= op;
    acc_in     <= a;
    stack1_in  <= s1;
    stack2_in  <= s2;
    operand_in <= opd;
    @(posedge sys_clk);
    op_start <= 1'b0;
    #1;
    wait_done();
  endtask

  // Clock enable low freezes a fill at its first word; it resumes where it stopped
  task automatic sc_freeze();
    @(posedge sys_clk);
    op_start   <= 1'b1;
    op_sel     <= table_fill_op;
    acc_in     <= 32'h90;
    stack1_in  <= 32'h2;
    operand_in <= 16'h7777;
    @(posedge sys_clk);
    op_start <= 1'b0;
    clk_en   <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(32'(busy), 32'h1);
    chk(32'(mem_we), 32'h1);
    chk(32'(mem_addr), 32'h90);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    #1;
    wait_done();
    chk(i_dcts_mem_model.mem[9'h090], 32'h7777);
    chk(i_dcts_mem_model.mem[9'h091], 32'h7777);
    chk(32'(busy), 32'h0);
  endtask

  // Character code of one nibble; 8'h37 + 10 gives the first letter
  function automatic logic [7:0] asc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  task automatic sc_hta();
    logic [15:0] w;
    for (int k = 0; k < 4; k++) begin
      i_dcts_mem_model.mem[16 + k] = {4'(4*k+3), 4'(4*k+2), 4'(4*k+1), 4'(4*k)};
    end
    i_dcts_mem_model.mem[9'h048] = 16'hdead;
    run_op(hex_to_ascii_op, 32'h10, 32'h4, 32'h0, 16'h0040);
    chk(acc_out, 32'h10);
    for (int k = 0; k < 4; k++) begin
      w = i_dcts_mem_model.mem[16 + k];
      chk(i_dcts_mem_model.mem[64 + 2*k], {asc(w[7:4]), asc(w[3:0])});
      chk(i_dcts_mem_model.mem[65 + 2*k], {asc(w[15:12]), asc(w[11:8])});
    end
    chk(i_dcts_mem_model.mem[9'h048], 32'hdead);
  endtask

  task automatic sc_seg_gray();
    logic [15:0] b;
    for (int k = 0; k < 4; k++) begin
      run_op(seven_segment_op, {16'h0, 4'(4*k+3), 4'(4*k+2), 4'(4*k+1), 4'(4*k)}, 32'h0, 32'h0, 16'h0);
      chk(acc_out, {1'b0, SEG_EXP[4*k+3], 1'b0, SEG_EXP[4*k+2], 1'b0, SEG_EXP[4*k+1], 1'b0, SEG_EXP[4*k]});
    end
    b = 16'd299;
    run_op(gray_to_bcd_op, {16'h0, b ^ (b >> 1)}, 32'h0, 32'h0, 16'h0);
    chk(acc_out, 32'h299);
    b = 16'd387;
    run_op(gray_to_bcd_op, {16'h0, b ^ (b >> 1)}, 32'h0, 32'h0, 16'h0);
    chk(acc_out, 32'h387);
    // Position 123 of a 360-count encoder arrives offset by 76
    b = 16'd199;
    run_op(gray_to_bcd_op, {16'h0, b ^ (b >> 1)}, 32'h0, 32'h0, 16'h0);
    chk(acc_out - 32'h76, 32'h123);
  endtask

  task automatic sc_shuffle();
    run_op(digit_shuffle_op, 32'h12345678, 32'h87654321, 32'h0, 16'h0);
    chk(acc_out, 32'h12345678);
    run_op(digit_shuffle_op, 32'h0a345678, 32'h87654321, 32'h0, 16'h0);
    chk(acc_out, 32'h12345600);
    run_op(digit_shuffle_op, 32'h11111111, 32'h87654321, 32'h0, 16'h0);
    chk(acc_out, 32'h00000008);
    run_op(digit_shuffle_op, 32'h9abcdef0, 32'h87654321, 32'h0, 16'h0);
    chk(acc_out, 32'h00000000);
    // Unused operation code only reports completion
    run_op(3'h7, 32'h13572468, 32'h0, 32'h0, 16'h0);
    chk(acc_out, 32'h13572468);
    chk(32'(not_found_flag), 32'h0);
  endtask

  task automatic sc_fill();
    i_dcts_mem_model.mem[9'h083] = 16'hbeef;
    i_dcts_mem_model.mem[9'h1ff] = 16'hbeef;
    run_op(table_fill_op, 32'h80, 32'h3, 32'h0, 16'h5a5a);
    chk(acc_out, 32'h80);
    for (int k = 0; k < 3; k++) begin
      chk(i_dcts_mem_model.mem[128 + k], 32'h5a5a);
    end
    run_op(table_fill_op, 32'h83, 32'h0, 32'h0, 16'h1111);
    chk(i_dcts_mem_model.mem[9'h083], 32'hbeef);
    run_op(table_fill_op, 32'h100, 32'hff, 32'h0, 16'h1234);
    chk(i_dcts_mem_model.mem[9'h100], 32'h1234);
    chk(i_dcts_mem_model.mem[9'h1fe], 32'h1234);
    chk(i_dcts_mem_model.mem[9'h1ff], 32'hbeef);
  endtask

  // Search of the six-word table at 20h; length, start, offset in hexadecimal
  task automatic find_eq(input logic [31:0] off, input logic [15:0] key, input logic [31:0] ea,
                         input logic ef);
    run_op(table_find_equal_op, off, 32'h20, 32'h6, key);
    chk(acc_out, ea);
    chk(32'(not_found_flag), 32'(ef));
  endtask

  task automatic sc_find();
    logic [15:0] tbl [6] = '{16'h5, 16'h7, 16'h9, 16'h7, 16'h3, 16'h1};
    for (int k = 0; k < 6; k++) begin
      i_dcts_mem_model.mem[32 + k] = tbl[k];
    end
    find_eq(32'h0, 16'h7, 32'h1, 1'b0);
    find_eq(32'h2, 16'h7, 32'h3, 1'b0);
    find_eq(32'h0, 16'h8, 32'h0, 1'b1);
    run_op(seven_segment_op, 32'h0, 32'h0, 32'h0, 16'h0);
    chk(32'(not_found_flag), 32'h1);
    find_eq(32'h6, 16'h7, 32'h0, 1'b1);
    find_eq(32'h0, 16'h5, 32'h0, 1'b0);
    run_op(table_find_greater_op, 32'h20, 32'h6, 32'h0, 16'h6);
    chk(acc_out, 32'h1);
    run_op(table_find_greater_op, 32'h20, 32'h6, 32'h0, 16'h9);
    chk(acc_out, 32'h0);
    chk(32'(not_found_flag), 32'h1);
  endtask

  // Main sequence
  initial begin
    n_fail     = 0;
    tests_run  = 0;
    sys_rst    = 1'b1;
    clk_en     = 1'b1;
    op_start   = 1'b0;
    op_sel     = 3'h0;
    acc_in     = '0;
    stack1_in  = '0;
    stack2_in  = '0;
    operand_in = '0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk(acc_out, 32'h0);
    chk(32'(not_found_flag), 32'h0);
    sc_hta();
    sc_seg_gray();
    sc_shuffle();
    sc_fill();
    sc_find();
    sc_freeze();
    tally_and_finish();
  end
endmodule
